// >>> hdl/jdb_ctrl.sv
// Jog and external DC-brake control behind assignable input terminals.
// Assumes input pins are asynchronous switches and an APB master on i_clk.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Jog output frequency capped at 10 Hz
// - Jog steps straight to frequency, no ramp
// - Jog input plus run command enters jog
// - Jog ends by coast, decel or brake
// - No jog if below start or zero
// - Brake input enables DC injection braking
// - Brake delay setting 0.1 to 5.0 s
// - Brake force setting 0 to 100 percent
// - Terminal run: release ramps back up
// - Keypad run: release leaves output off
// - Delayed keypad case coasts, then brakes
module jdb_ctrl #(
  parameter int unsigned TENTH_CYCLES = jdb_pkg::TENTH_SEC_CYCLES,
  parameter int unsigned RAMP_CYCLES = jdb_pkg::RAMP_STEP_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Input terminal pins
  input wire logic [4:0] i_terminal,
  input wire logic i_forward_run_input,
  input wire logic i_reverse_run_input,
  // Drive command outputs
  output logic [15:0] o_freq_cmd,
  output logic o_output_on,
  output logic o_dc_brake,
  output logic [6:0] o_brake_force,
  output logic o_reverse
);

  // ****************************************************************
  // Pin synchronisation and terminal decode
  // ****************************************************************
  logic [6:0] pins_s;
  logic [4:0] term_s;
  logic jog_input;
  logic dc_brake_input;
  logic [4:0] jog_hit;
  logic [4:0] brk_hit;
  logic [5:0] ctrl_ff;
  logic [24:0] assign_ff;

  jdb_sync2 #(.W(7)) u_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_async({i_reverse_run_input, i_forward_run_input, i_terminal}),
    .o_sync(pins_s)
  );
  assign term_s = pins_s[4:0];

  // Each terminal carries the function code assigned to it
  for (genvar g = 0; g < jdb_pkg::NUM_TERM; g++) begin : g_term
    assign jog_hit[g] = term_s[g] &&
      (assign_ff[g*jdb_pkg::FN_W +: jdb_pkg::FN_W] == jdb_pkg::FN_JOG);
    assign brk_hit[g] = term_s[g] &&
      (assign_ff[g*jdb_pkg::FN_W +: jdb_pkg::FN_W] == jdb_pkg::FN_DC_BRAKE);
  end
  assign jog_input = |jog_hit;
  assign dc_brake_input = |brk_hit;

  // ****************************************************************
  // APB register file
  // ****************************************************************
  logic [15:0] jogf_ff;
  logic [15:0] startf_ff;
  logic [15:0] targetf_ff;
  logic [5:0] delay_ff;
  logic [6:0] force_ff;
  logic kp_run_ff;
  logic wr_en;
  logic mapped;
  logic kp_clear;
  jdb_pkg::jdb_state_t state_ff;
  logic [15:0] freq_ff;
  logic run_cmd;
  logic [5:0] wr_delay;
  logic [6:0] wr_force;

  // Address decode; every access completes with no wait state
  always_comb begin
    unique case (i_paddr)
      jdb_pkg::OFS_CTRL, jdb_pkg::OFS_KEYPAD, jdb_pkg::OFS_JOG_FREQ,
      jdb_pkg::OFS_START_FREQ, jdb_pkg::OFS_TARGET_FREQ,
      jdb_pkg::OFS_BRAKE_DELAY, jdb_pkg::OFS_BRAKE_FORCE,
      jdb_pkg::OFS_ASSIGN, jdb_pkg::OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign wr_en = i_psel && i_penable && i_pwrite && mapped;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;

  // Brake delay and force settings are clamped into their legal ranges when written
  assign wr_delay = (i_pwdata[31:6] != '0 || i_pwdata[5:0] > jdb_pkg::DELAY_MAX) ?
                    jdb_pkg::DELAY_MAX : (i_pwdata[5:0] < jdb_pkg::DELAY_MIN) ?
                    jdb_pkg::DELAY_MIN : i_pwdata[5:0];
  assign wr_force = (i_pwdata[6:0] > jdb_pkg::FORCE_MAX || i_pwdata[31:7] != '0) ?
                    jdb_pkg::FORCE_MAX : i_pwdata[6:0];

  // Configuration registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_ff <= jdb_pkg::CTRL_RST;
      jogf_ff <= jdb_pkg::JOG_FREQ_RST;
      startf_ff <= jdb_pkg::START_FREQ_RST;
      targetf_ff <= jdb_pkg::TARGET_FREQ_RST;
      delay_ff <= jdb_pkg::BRAKE_DELAY_RST;
      force_ff <= jdb_pkg::BRAKE_FORCE_RST;
      assign_ff <= jdb_pkg::ASSIGN_RST;
    end else if (wr_en) begin
      unique case (i_paddr)
        jdb_pkg::OFS_CTRL: ctrl_ff <= i_pwdata[5:0];
        jdb_pkg::OFS_JOG_FREQ: jogf_ff <= i_pwdata[15:0];
        jdb_pkg::OFS_START_FREQ: startf_ff <= i_pwdata[15:0];
        jdb_pkg::OFS_TARGET_FREQ: targetf_ff <= i_pwdata[15:0];
        jdb_pkg::OFS_BRAKE_DELAY: delay_ff <= wr_delay;
        jdb_pkg::OFS_BRAKE_FORCE: force_ff <= wr_force;
        jdb_pkg::OFS_ASSIGN: assign_ff <= i_pwdata[24:0];
        default: ;
      endcase
    end
  end

  // Keypad run latch; a start write wins over any clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      kp_run_ff <= 1'b0;
    end else if (wr_en && i_paddr == jdb_pkg::OFS_KEYPAD && i_pwdata[jdb_pkg::KP_START_BIT]) begin
      kp_run_ff <= 1'b1;
    end else if (kp_clear ||
                 (wr_en && i_paddr == jdb_pkg::OFS_KEYPAD && i_pwdata[jdb_pkg::KP_STOP_BIT])) begin
      kp_run_ff <= 1'b0;
    end
  end

  // Read mux; status shows the live drive state
  always_comb begin
    o_prdata = 32'h00000000;
    unique case (i_paddr)
      jdb_pkg::OFS_CTRL: o_prdata[5:0] = ctrl_ff;
      jdb_pkg::OFS_KEYPAD: o_prdata[0] = kp_run_ff;
      jdb_pkg::OFS_JOG_FREQ: o_prdata[15:0] = jogf_ff;
      jdb_pkg::OFS_START_FREQ: o_prdata[15:0] = startf_ff;
      jdb_pkg::OFS_TARGET_FREQ: o_prdata[15:0] = targetf_ff;
      jdb_pkg::OFS_BRAKE_DELAY: o_prdata[5:0] = delay_ff;
      jdb_pkg::OFS_BRAKE_FORCE: o_prdata[6:0] = force_ff;
      jdb_pkg::OFS_ASSIGN: o_prdata[24:0] = assign_ff;
      jdb_pkg::OFS_STATUS: o_prdata[23:0] = {dc_brake_input, jog_input, run_cmd,
                                             kp_run_ff, 1'b0, state_ff, freq_ff};
      default: o_prdata = 32'h00000000;
    endcase
  end

  // ****************************************************************
  // Run command, jog qualification
  // ****************************************************************
  logic [1:0] run_src;
  logic [1:0] stop_sel;
  logic delay_en;
  logic term_mode;
  logic jog_ok;
  logic jog_go;
  logic [15:0] jog_lim;

  assign run_src = ctrl_ff[jdb_pkg::CTRL_SRC_LSB +: 2];
  assign stop_sel = ctrl_ff[jdb_pkg::CTRL_STOP_LSB +: 2];
  assign delay_en = ctrl_ff[jdb_pkg::CTRL_DELAY_BIT];
  assign term_mode = (run_src == jdb_pkg::SRC_TERMINAL);
  assign run_cmd = term_mode ? (pins_s[5] | pins_s[6]) :
                   (run_src == jdb_pkg::SRC_KEYPAD) && kp_run_ff;
  assign jog_ok = (jogf_ff != 16'h0000) && (jogf_ff >= startf_ff);
  assign jog_lim = (jogf_ff > jdb_pkg::JOG_MAX_FREQ) ? jdb_pkg::JOG_MAX_FREQ : jogf_ff;
  assign jog_go = jog_input && run_cmd && jog_ok;

  // ****************************************************************
  // Timers: brake delay in tenths and ramp steps
  // ****************************************************************
  jdb_pkg::jdb_state_t nxt_state;
  logic tenth_tick;
  logic ramp_tick;
  logic enter_timed;
  logic [5:0] cnt_ff;

  assign enter_timed = (nxt_state != state_ff) &&
                       (nxt_state == jdb_pkg::ST_WAIT || nxt_state == jdb_pkg::ST_JBRAKE);

  jdb_tick #(.PERIOD(TENTH_CYCLES)) u_tenth (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_restart(enter_timed),
    .o_tick(tenth_tick)
  );

  jdb_tick #(.PERIOD(RAMP_CYCLES)) u_ramp (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_restart(1'b0),
    .o_tick(ramp_tick)
  );

  // Delay counter loaded afresh on each entry into a timed state
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_ff <= '0;
    end else if (enter_timed) begin
      cnt_ff <= (nxt_state == jdb_pkg::ST_WAIT) ? delay_ff : jdb_pkg::JOG_BRAKE_TENTHS;
    end else if (tenth_tick && cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  // ****************************************************************
  // Drive state machine
  // ****************************************************************
  logic brake_req;
  logic released;

  assign brake_req = dc_brake_input && (state_ff == jdb_pkg::ST_RUN ||
                     state_ff == jdb_pkg::ST_JOG || state_ff == jdb_pkg::ST_DECEL);
  assign released = !dc_brake_input &&
                    (state_ff == jdb_pkg::ST_WAIT || state_ff == jdb_pkg::ST_BRAKE);
  assign kp_clear = released && !term_mode;

  // Next state; in run, jog and decel the brake input outranks jog and run
  always_comb begin
    nxt_state = state_ff;
    if (brake_req) begin
      nxt_state = (delay_en && !term_mode) ? jdb_pkg::ST_WAIT : jdb_pkg::ST_BRAKE;
    end else begin
      unique case (state_ff)
        jdb_pkg::ST_STOP: begin
          if (jog_go) nxt_state = jdb_pkg::ST_JOG;
          else if (run_cmd && !jog_input) nxt_state = jdb_pkg::ST_RUN;
        end
        jdb_pkg::ST_RUN: begin
          if (!run_cmd) nxt_state = jdb_pkg::ST_DECEL;
        end
        jdb_pkg::ST_JOG: begin
          if (!jog_go) begin
            unique case (stop_sel)
              jdb_pkg::STOP_DECEL: nxt_state = jdb_pkg::ST_DECEL;
              jdb_pkg::STOP_DCBRAKE: nxt_state = jdb_pkg::ST_JBRAKE;
              default: nxt_state = jdb_pkg::ST_STOP;
            endcase
          end
        end
        jdb_pkg::ST_DECEL: begin
          if (run_cmd && !jog_input) nxt_state = jdb_pkg::ST_RUN;
          else if (freq_ff == 16'h0000) nxt_state = jdb_pkg::ST_STOP;
        end
        jdb_pkg::ST_WAIT, jdb_pkg::ST_BRAKE: begin
          if (!dc_brake_input) begin
            nxt_state = (term_mode && run_cmd) ? jdb_pkg::ST_RUN : jdb_pkg::ST_STOP;
          end else if (state_ff == jdb_pkg::ST_WAIT && cnt_ff == '0) begin
            nxt_state = jdb_pkg::ST_BRAKE;
          end
        end
        jdb_pkg::ST_JBRAKE: begin
          if (cnt_ff == '0) nxt_state = jdb_pkg::ST_STOP;
        end
        default: nxt_state = jdb_pkg::ST_STOP;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) state_ff <= jdb_pkg::ST_STOP;
    else state_ff <= nxt_state;
  end

  // ****************************************************************
  // Output frequency and brake command
  // ****************************************************************
  logic [15:0] nxt_freq;

  // Jog steps at once; run and decel ramp one unit per tick
  always_comb begin
    nxt_freq = freq_ff;
    if (nxt_state == jdb_pkg::ST_JOG) begin
      nxt_freq = jog_lim;
    end else if (nxt_state == jdb_pkg::ST_RUN && state_ff != jdb_pkg::ST_RUN &&
                 state_ff != jdb_pkg::ST_DECEL) begin
      nxt_freq = 16'h0000;
    end else if (nxt_state == jdb_pkg::ST_RUN && ramp_tick && freq_ff != targetf_ff) begin
      nxt_freq = (freq_ff < targetf_ff) ? freq_ff + 16'h0001 : freq_ff - 16'h0001;
    end else if (nxt_state == jdb_pkg::ST_DECEL && ramp_tick && freq_ff != 16'h0000) begin
      nxt_freq = freq_ff - 16'h0001;
    end else if (nxt_state != jdb_pkg::ST_RUN && nxt_state != jdb_pkg::ST_DECEL) begin
      nxt_freq = 16'h0000;
    end
  end

  // Registered drive outputs
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      freq_ff <= 16'h0000;
      o_reverse <= 1'b0;
    end else begin
      freq_ff <= nxt_freq;
      o_reverse <= term_mode ? (pins_s[6] && !pins_s[5]) : ctrl_ff[jdb_pkg::CTRL_REV_BIT];
    end
  end

  // Brake force applied only while braking
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) o_brake_force <= 7'h00;
    else if (nxt_state == jdb_pkg::ST_BRAKE || nxt_state == jdb_pkg::ST_JBRAKE)
      o_brake_force <= force_ff;
    else o_brake_force <= 7'h00;
  end

  assign o_freq_cmd = freq_ff;
  assign o_dc_brake = (state_ff == jdb_pkg::ST_BRAKE) || (state_ff == jdb_pkg::ST_JBRAKE);
  assign o_output_on = (state_ff != jdb_pkg::ST_STOP) && (state_ff != jdb_pkg::ST_WAIT);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence seq_release;
    (state_ff == jdb_pkg::ST_BRAKE || state_ff == jdb_pkg::ST_WAIT) && !dc_brake_input;
  endsequence
  sequence seq_resume;
    state_ff == jdb_pkg::ST_RUN && freq_ff == 16'h0000 && o_output_on;
  endsequence

  chk_jog_freq_cap: assert property (state_ff == jdb_pkg::ST_JOG |->
    freq_ff <= jdb_pkg::JOG_MAX_FREQ) else $error("jog frequency above cap");
  chk_jog_no_ramp: assert property ($rose(state_ff == jdb_pkg::ST_JOG) |->
    freq_ff == $past(jog_lim)) else $error("jog did not step to frequency");
  chk_jog_entry: assert property (state_ff == jdb_pkg::ST_STOP && jog_go
    && !dc_brake_input |=> state_ff == jdb_pkg::ST_JOG) else $error("jog not entered");
  chk_jog_coast: assert property (state_ff == jdb_pkg::ST_JOG && !jog_go
    && !dc_brake_input && stop_sel == jdb_pkg::STOP_COAST |=> !o_output_on)
    else $error("jog coast stop missed");
  chk_jog_invalid: assert property (state_ff != jdb_pkg::ST_JOG && !jog_ok |=>
    state_ff != jdb_pkg::ST_JOG) else $error("jog with invalid frequency");
  chk_brake_gate: assert property (o_dc_brake && state_ff == jdb_pkg::ST_BRAKE |->
    $past(dc_brake_input)) else $error("braking without input");
  chk_delay_range: assert property (delay_ff >= jdb_pkg::DELAY_MIN &&
    delay_ff <= jdb_pkg::DELAY_MAX) else $error("brake delay out of range");
  chk_force_range: assert property (o_brake_force <= jdb_pkg::FORCE_MAX &&
    (!o_dc_brake -> o_brake_force == 7'h00)) else $error("brake force out of range");
  chk_term_resume: assert property (seq_release ##0 (term_mode && run_cmd) |=>
    seq_resume) else $error("no ramp back after release");
  chk_keypad_off: assert property (seq_release ##0 !term_mode |=>
    state_ff == jdb_pkg::ST_STOP && !o_output_on && (!kp_run_ff || $past(wr_en)))
    else $error("output not off after keypad release");
  chk_wait_coast: assert property (state_ff == jdb_pkg::ST_WAIT |->
    !o_output_on && !o_dc_brake) else $error("output on during brake delay");
  chk_delay_restart: assert property ($rose(state_ff == jdb_pkg::ST_WAIT) |->
    cnt_ff == $past(delay_ff)) else $error("delay counter not restarted");

endmodule : jdb_ctrl
`default_nettype wire

// >>> hdl/jdb_sync2.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are quasi-static levels from switches.
`timescale 1ns/10ps
`default_nettype none
module jdb_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Two stages; only the second is read outside
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule : jdb_sync2
`default_nettype wire

// >>> hdl/jdb_tick.sv
// Restartable period ticker giving a one-cycle pulse every PERIOD cycles.
// Assumes a restart pulse from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module jdb_tick #(
  parameter int unsigned PERIOD = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Control
  input wire logic i_restart,
  output logic o_tick
);

  localparam int CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] cnt_ff;

  // Count up to PERIOD-1, restart from zero on request
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_ff <= '0;
    end else if (i_restart || cnt_ff == LAST) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign o_tick = (cnt_ff == LAST) && !i_restart;

endmodule : jdb_tick
`default_nettype wire

// >>> shared/jdb_pkg.sv
// Package for the jog and external DC-brake input control block.
// Assumes a 125 MHz system clock and a 32-bit APB register bus.
package jdb_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_KEYPAD = 8'h04;
  localparam logic [7:0] OFS_JOG_FREQ = 8'h08;
  localparam logic [7:0] OFS_START_FREQ = 8'h0C;
  localparam logic [7:0] OFS_TARGET_FREQ = 8'h10;
  localparam logic [7:0] OFS_BRAKE_DELAY = 8'h14;
  localparam logic [7:0] OFS_BRAKE_FORCE = 8'h18;
  localparam logic [7:0] OFS_ASSIGN = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_STOP_LSB = 2;
  localparam int CTRL_DELAY_BIT = 4;
  localparam int CTRL_REV_BIT = 5;
  localparam int KP_START_BIT = 0;
  localparam int KP_STOP_BIT = 1;
  localparam int FN_W = 5;
  localparam int NUM_TERM = 5;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [15:0] JOG_FREQ_RST = 16'h0000;
  localparam logic [15:0] START_FREQ_RST = 16'h0000;
  localparam logic [15:0] TARGET_FREQ_RST = 16'h0000;
  localparam logic [5:0] BRAKE_DELAY_RST = 6'h01;
  localparam logic [6:0] BRAKE_FORCE_RST = 7'h00;
  localparam logic [24:0] ASSIGN_RST = 25'h0000000;

  // ****************************************************************
  // Codes and limits (frequencies in 0.1 Hz, delay in 0.1 s)
  // ****************************************************************
  localparam logic [1:0] SRC_KEYPAD = 2'h0;
  localparam logic [1:0] SRC_TERMINAL = 2'h1;
  localparam logic [1:0] STOP_COAST = 2'h0;
  localparam logic [1:0] STOP_DECEL = 2'h1;
  localparam logic [1:0] STOP_DCBRAKE = 2'h2;
  localparam logic [4:0] FN_JOG = 5'h06;
  localparam logic [4:0] FN_DC_BRAKE = 5'h07;
  localparam logic [15:0] JOG_MAX_FREQ = 16'h0064;
  localparam logic [5:0] DELAY_MIN = 6'h01;
  localparam logic [5:0] DELAY_MAX = 6'h32;
  localparam logic [6:0] FORCE_MAX = 7'h64;
  localparam logic [5:0] JOG_BRAKE_TENTHS = 6'h05;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TENTH_SEC_NS = 100_000_000;
  localparam int unsigned TENTH_SEC_CYCLES = (TENTH_SEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RAMP_STEP_NS = 1_000_000;
  localparam int unsigned RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Drive states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_STOP, ST_RUN, ST_JOG, ST_DECEL, ST_WAIT, ST_BRAKE, ST_JBRAKE
  } jdb_state_t;

endpackage : jdb_pkg

// >>> verification/jdb_ctrl_tb.sv
// Self-checking bench for the jog and DC-brake control block.
// Assumes the switch model on the pins and shortened timing parameters.
`timescale 1ns/10ps
`default_nettype none
module jdb_ctrl_tb;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int TC = 20;
  logic clk, rst_n, slv, on, brk, rev, fwd, rv, pready, pslverr;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [6:0] want = 7'h00, frc;
  logic [4:0] term;
  logic [15:0] freq;
  int err_total = 0, n_tests = 0, cyc = 0;
  typedef struct packed {
    logic [15:0] jog, st;
    logic [1:0] stop;
    logic [15:0] f;
    logic on, brk;
  } jdb_row_t;
  // Jog setting, start setting, stop method, frequency, output on, braking
  jdb_row_t rows [5] = '{
    '{16'h0032, 16'h0000, 2'h1, 16'h0032, 1'b1, 1'b0},
    '{16'h00C8, 16'h0000, 2'h2, 16'h0064, 1'b1, 1'b1},
    '{16'h0028, 16'h0028, 2'h0, 16'h0028, 1'b1, 1'b0},
    '{16'h0000, 16'h0000, 2'h0, 16'h0000, 1'b0, 1'b0},
    '{16'h001E, 16'h0028, 2'h2, 16'h0000, 1'b0, 1'b0}};
  jdb_switches u_sw (.i_clk(clk), .i_want(want), .o_terminal(term), .o_fwd(fwd), .o_rev(rv));
  jdb_ctrl #(.TENTH_CYCLES(TC), .RAMP_CYCLES(4)) u_dut (.i_clk(clk), .i_arst_n(rst_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_terminal(term),
    .i_forward_run_input(fwd), .i_reverse_run_input(rv), .o_freq_cmd(freq),
    .o_output_on(on), .o_dc_brake(brk), .o_brake_force(frc), .o_reverse(rev));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Compares and counts
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // Counts, verdict and end of run
  task automatic results;
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  // ****************************************************************
  // Clock and hang guard
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    wt(3);
    rst_n <= 1'b1;
    chk({on, brk, freq}, 32'h0);
    apb(1'b0, jdb_pkg::OFS_BRAKE_DELAY, 32'h0);
    chk(rd, 32'h1);
    chk(slv, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    chk(slv, 1'b1);
    chk(rd, 32'h0);
    chk(pready, 1'b1);
    apb(1'b1, jdb_pkg::OFS_BRAKE_DELAY, 32'h64);
    apb(1'b0, jdb_pkg::OFS_BRAKE_DELAY, 32'h0);
    chk(rd, 32'h32);
    apb(1'b1, jdb_pkg::OFS_BRAKE_DELAY, 32'h40);
    apb(1'b0, jdb_pkg::OFS_BRAKE_DELAY, 32'h0);
    chk(rd, 32'h32);
    apb(1'b1, jdb_pkg::OFS_BRAKE_DELAY, 32'h0);
    apb(1'b0, jdb_pkg::OFS_BRAKE_DELAY, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, jdb_pkg::OFS_ASSIGN, 32'hE6);
    // Jog table: terminal 0 jogs with forward run, terminal source
    foreach (rows[i]) begin
      apb(1'b1, jdb_pkg::OFS_JOG_FREQ, {16'h0, rows[i].jog});
      apb(1'b1, jdb_pkg::OFS_START_FREQ, {16'h0, rows[i].st});
      apb(1'b1, jdb_pkg::OFS_CTRL, {28'h0, rows[i].stop, 2'h1});
      want <= 7'h21;
      wt(5);
      chk({freq, on, brk}, {rows[i].f, rows[i].on, 1'b0});
      want <= 7'h00;
      wt(6);
      chk(brk, rows[i].brk);
      if (rows[i].stop == 2'h0) chk(on, 1'b0);
      wt(450);
      chk(on, 1'b0);
    end
    // Terminal run, brake on and off, force clamped
    apb(1'b1, jdb_pkg::OFS_CTRL, 32'h1);
    apb(1'b1, jdb_pkg::OFS_TARGET_FREQ, 32'h50);
    apb(1'b1, jdb_pkg::OFS_BRAKE_FORCE, 32'h96);
    apb(1'b0, jdb_pkg::OFS_BRAKE_FORCE, 32'h0);
    chk(rd, 32'h64);
    want <= 7'h20;
    wt(400);
    want <= 7'h22;
    wt(6);
    chk({brk, frc}, {1'b1, 7'h64});
    want <= 7'h20;
    wt(6);
    chk({brk, on, freq < 16'h0010}, 3'h3);
    wt(400);
    chk(freq, 16'h0050);
    chk(rev, 1'b0);
    apb(1'b0, jdb_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h00210050);
    // Mid-run reset, then keypad run with delayed braking
    want <= 7'h00;
    rst_n <= 1'b0;
    wt(3);
    rst_n <= 1'b1;
    chk({on, freq}, 32'h0);
    apb(1'b1, jdb_pkg::OFS_ASSIGN, 32'hE6);
    apb(1'b1, jdb_pkg::OFS_CTRL, 32'h30);
    apb(1'b1, jdb_pkg::OFS_BRAKE_DELAY, 32'h2);
    apb(1'b1, jdb_pkg::OFS_KEYPAD, 32'h1);
    wt(10);
    chk(on, 1'b1);
    chk(rev, 1'b1);
    want <= 7'h02;
    wt(6);
    chk({on, brk}, 2'h0);
    want <= 7'h00;
    wt(6);
    apb(1'b1, jdb_pkg::OFS_KEYPAD, 32'h1);
    wt(4);
    want <= 7'h02;
    wt(32);
    chk(brk, 1'b0);
    wt(20);
    chk(brk, 1'b1);
    want <= 7'h00;
    wt(6);
    chk({on, brk}, 2'h0);
    results();
  end
endmodule : jdb_ctrl_tb
`default_nettype wire

// >>> verification/jdb_switches.sv
// Switch model for the input terminals and run switches.
// Assumes the bench sets a wanted pattern; pins move on the next edge.
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Switch bank
// ****************************************************************
module jdb_switches (
  // Clock
  input wire logic i_clk,
  // Wanted levels: [4:0] terminals, [5] forward, [6] reverse
  input wire logic [6:0] i_want,
  // Pin levels
  output logic [4:0] o_terminal,
  output logic o_fwd,
  output logic o_rev
);
  // Switches start open and settle one edge after a request
  initial {o_rev, o_fwd, o_terminal} = 7'h00;
  always @(posedge i_clk) begin
    {o_rev, o_fwd, o_terminal} <= i_want;
  end
endmodule : jdb_switches
`default_nettype wire
